// >>> src/tick_timer_watchdog.sv
// Tick timer and watchdog unit: prescaler, 16-bit reload timer, watchdog counter.
// Assumes synchronous inputs on ref_clk and a register master that never waits.

`default_nettype none

module tick_timer_watchdog #(
   parameter int SLOW_DIV = tick_wdog_pkg::SLOW_DIV
) (
   // Clock and reset
   input  wire  logic        ref_clk,
   input  wire  logic        rst_n,
   // Register port
   input  wire  logic [3:0]  reg_addr,
   input  wire  logic [15:0] reg_wdata,
   input  wire  logic        reg_wr,
   input  wire  logic        reg_rd,
   output var   logic [15:0] reg_rdata,
   // Debug freeze request
   input  wire  logic        freeze,
   // Events
   output var   logic        tick_irq,
   output var   logic        watchdog_error,
   output var   logic        watchdog_active
);
   import tick_wdog_pkg::*;

   // ------------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------------

   // Mask of prescaler counter bits that must all be one for a divided tick.
   function automatic logic [4:0] div_mask(input logic [2:0] code);
      logic [4:0] m;
      m = '0;
      for (int i = 0; i < 5; i++) begin
         if (i < int'(code)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   localparam int SDW = $clog2(SLOW_DIV + 1);

   logic [SDW-1:0]         slow_cnt_r;
   logic [4:0]             pre_cnt_r;
   timer_watchdog_config_t cfg_r;
   logic [2:0]             div_code_r;
   logic [15:0]            preset_r;
   logic [15:0]            tick_cnt_r;
   logic                   restart_r;
   logic                   tc_r;
   logic                   inte_r;
   logic                   frze_r;
   logic [7:0]             reload_r;
   logic [7:0]             wd_cnt_r;
   logic [7:0]             pend_val_r;
   logic                   pend_r;
   logic                   serviced_r;
   logic                   active_r;
   logic                   error_r;
   logic                   irq_r;
   logic [15:0]            rdata_r;

   // ------------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------------
   wire logic wr_cfg  = reg_wr && reg_addr == OFS_CONFIG    && !cfg_r.lock_config;
   wire logic wr_pre  = reg_wr && reg_addr == OFS_PRESCALER && !cfg_r.lock_prescaler;
   wire logic wr_pset = reg_wr && reg_addr == OFS_PRESET    && !cfg_r.lock_timer;
   wire logic wr_csr  = reg_wr && reg_addr == OFS_CSR       && !cfg_r.lock_timer;
   wire logic wr_rld  = reg_wr && reg_addr == OFS_RELOAD    && !cfg_r.lock_reload;
   wire logic wr_svc  = reg_wr && reg_addr == OFS_SERVICE && cfg_r.match_service_enable;
   wire logic rd_csr  = reg_rd && reg_addr == OFS_CSR       && !cfg_r.lock_timer;

   // ------------------------------------------------------------------------
   // Clock enables
   // ------------------------------------------------------------------------

   // Slow clock enable; the divider stands in for the external 32 kHz source.
   wire logic slow_en = slow_cnt_r == SDW'(SLOW_DIV - 1);

   // Reserved codes stop the prescaled clock rather than guess a rate.
   wire logic code_ok = div_code_r <= DIV_CODE_MAX;
   wire logic [4:0] mask = div_mask(div_code_r);
   wire logic prescaled_slow_clock_en = slow_en && code_ok && ((pre_cnt_r & mask) == mask);

   wire logic frozen  = frze_r && freeze;
   wire logic run_en  = prescaled_slow_clock_en && !frozen && !restart_r;
   wire logic tick_underflow_clock   = run_en && tick_cnt_r == 16'h0000;
   wire logic zero_hit = run_en && tick_cnt_r == 16'h0001;
   wire logic wd_clk  = cfg_r.watchdog_clock_select ? prescaled_slow_clock_en : tick_underflow_clock;

   // Watchdog expiry: a running count reaches zero with no reload waiting.
   wire logic wd_expire = wd_clk && active_r && !pend_r && wd_cnt_r <= 8'h01;

   // Service write outcomes.
   wire logic svc_match = wr_svc && reg_wdata[7:0] == SERVICE_MATCH;
   wire logic svc_bad   = wr_svc && reg_wdata[7:0] != SERVICE_MATCH;
   wire logic svc_twice = svc_match && serviced_r;
   wire logic svc_ok    = svc_match && !serviced_r;

   // ------------------------------------------------------------------------
   // Slow clock divider and prescaler
   // ------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         slow_cnt_r <= '0;
         pre_cnt_r  <= '0;
      end else begin
         slow_cnt_r <= slow_en ? '0 : slow_cnt_r + SDW'(1);
         if (slow_en) begin
            pre_cnt_r <= pre_cnt_r + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Configuration and prescaler registers
   // ------------------------------------------------------------------------

   // Lock bits are sticky: a write may set them but never clear them.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_r      <= CONFIG_RST;
         div_code_r <= '0;
      end else begin
         if (wr_cfg) begin
            cfg_r.match_service_enable  <= reg_wdata[5];
            cfg_r.watchdog_clock_select <= reg_wdata[4];
            cfg_r.lock_reload    <= cfg_r.lock_reload    | reg_wdata[3];
            cfg_r.lock_timer     <= cfg_r.lock_timer     | reg_wdata[2];
            cfg_r.lock_prescaler <= cfg_r.lock_prescaler | reg_wdata[1];
            cfg_r.lock_config    <= cfg_r.lock_config    | reg_wdata[0];
         end
         if (wr_pre) begin
            div_code_r <= reg_wdata[2:0];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Tick timer
   // ------------------------------------------------------------------------

   // Preset zero is not a legal setting; it would make the timer sit at zero.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         preset_r   <= PRESET_RST;
         tick_cnt_r <= PRESET_RST;
      end else begin
         if (wr_pset) begin
            preset_r <= reg_wdata;
         end
         if (prescaled_slow_clock_en && restart_r) begin
            tick_cnt_r <= preset_r;
         end else if (tick_underflow_clock) begin
            tick_cnt_r <= preset_r;
         end else if (run_en) begin
            tick_cnt_r <= tick_cnt_r - 16'h0001;
         end
      end
   end

   // Control and status bits; the flag set by the counter wins over a read clear.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         restart_r <= 1'b0;
         tc_r      <= 1'b0;
         inte_r    <= 1'b0;
         frze_r    <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         if (wr_csr && reg_wdata[CSR_RESTART]) begin
            restart_r <= 1'b1;
         end else if (prescaled_slow_clock_en) begin
            restart_r <= 1'b0;
         end
         if (wr_csr) begin
            inte_r <= reg_wdata[CSR_INTE];
            frze_r <= reg_wdata[CSR_FRZE];
         end
         if (zero_hit) begin
            tc_r <= 1'b1;
         end else if (rd_csr) begin
            tc_r <= 1'b0;
         end
         irq_r <= zero_hit && inte_r;
      end
   end

   // ------------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------------

   // A written count waits for the next watchdog clock before it lands in the
   // counter, so the pending flag shows software the transfer is still open.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reload_r   <= RELOAD_RST;
         wd_cnt_r   <= RELOAD_RST;
         pend_val_r <= RELOAD_RST;
         pend_r     <= 1'b0;
         serviced_r <= 1'b0;
         active_r   <= 1'b0;
         error_r    <= 1'b0;
      end else begin
         if (wd_clk && pend_r) begin
            wd_cnt_r <= pend_val_r;
            pend_r   <= 1'b0;
         end else if (wd_clk && active_r && wd_cnt_r != 8'h00) begin
            wd_cnt_r <= wd_cnt_r - 8'h01;
         end
         if (wd_clk) begin
            serviced_r <= 1'b0;
         end
         if (wr_rld) begin
            reload_r   <= reg_wdata[7:0];
            pend_val_r <= reg_wdata[7:0];
            pend_r     <= 1'b1;
            active_r   <= 1'b1;
         end else if (svc_ok) begin
            pend_val_r <= reload_r;
            pend_r     <= 1'b1;
         end
         if (svc_match) begin
            serviced_r <= 1'b1;
         end
         // The error is sticky until reset so a reset controller cannot miss it.
         if (wd_expire || svc_bad || svc_twice) begin
            error_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------------

   // Locked and write-only registers read as zero.
   wire logic [7:0] csr_view = {3'h0, frze_r, pend_r, inte_r, tc_r, restart_r};
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      unique case (reg_addr)
         OFS_CONFIG:    rd_mux = cfg_r.lock_config ? 16'h0000 : {8'h00, 2'h0, cfg_r[5:0]};
         OFS_PRESCALER: rd_mux = cfg_r.lock_prescaler ? 16'h0000 : {13'h0000, div_code_r};
         OFS_PRESET:    rd_mux = cfg_r.lock_timer ? 16'h0000 : preset_r;
         OFS_CSR:       rd_mux = cfg_r.lock_timer ? 16'h0000 : {8'h00, csr_view};
         default:       rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign reg_rdata       = rdata_r;
   assign tick_irq        = irq_r;
   assign watchdog_error  = error_r;
   assign watchdog_active = active_r;

endmodule

`default_nettype wire

// >>> src/tick_wdog_pkg.sv
// Constants, register map and field layout of the tick timer and watchdog unit.
// Assumes a 40 MHz system clock from which the slow clock rate is divided.
//
// Summary of operation
// - After reset the tick timer preset holds ffff.
// - Tick timer reloads preset at underflow; rate is input clock over preset plus one.
// - After reset all non-reserved control and status bits are zero.
// - Status bit 3 reads one while a watchdog count transfer is pending.
// - With freeze enable set, the freeze input stops the tick timer.
// - Watchdog reload count is write-only and holds 0f after reset.
// - Watchdog stays idle after reset until the first reload count write.
// - Each reload count write restarts the watchdog from the written value.
// - With match servicing, writing 5c reloads the watchdog from the last reload count.
// - With match servicing, writing any other service byte raises the watchdog error.
// - With match servicing, two service writes in one watchdog clock raise the error.
// - With match servicing off, service register writes are ignored.
// - Reload count sets the most watchdog clocks allowed between services.
// - Tick timer input is selectable among six rates, slow clock over 1 to 32.
// - A set lock bit hides and write-protects its target register until reset.
// - Watchdog clock is tick underflow when select is clear, prescaled clock when set.
// - Prescaler code divides slow clock by one to thirty-two; higher codes reserved.

`default_nettype none

package tick_wdog_pkg;

   // -------------------------------------------------------------------------
   // Register offsets (byte addresses on the register port)
   // -------------------------------------------------------------------------
   localparam logic [3:0] OFS_CONFIG    = 4'h0;
   localparam logic [3:0] OFS_PRESCALER = 4'h2;
   localparam logic [3:0] OFS_PRESET    = 4'h4;
   localparam logic [3:0] OFS_CSR       = 4'h6;
   localparam logic [3:0] OFS_RELOAD    = 4'h8;
   localparam logic [3:0] OFS_SERVICE   = 4'ha;

   // -------------------------------------------------------------------------
   // Reset values and fixed codes
   // -------------------------------------------------------------------------
   localparam logic [15:0] PRESET_RST      = 16'hffff;
   localparam logic [7:0]  RELOAD_RST      = 8'h0f;
   localparam logic [7:0]  SERVICE_MATCH   = 8'h5c;
   localparam logic [2:0]  DIV_CODE_MAX    = 3'h5;

   // Control and status bit positions.
   localparam int CSR_RESTART = 0;
   localparam int CSR_TC      = 1;
   localparam int CSR_INTE    = 2;
   localparam int CSR_PEND    = 3;
   localparam int CSR_FRZE    = 4;

   // Slow clock: 40 MHz system clock over 32.768 kHz, rounded to whole cycles.
   localparam int SYS_CLK_HZ  = 40000000;
   localparam int SLOW_CLK_HZ = 32768;
   localparam int SLOW_DIV    = (SYS_CLK_HZ + SLOW_CLK_HZ / 2) / SLOW_CLK_HZ;

   // Configuration byte: locks in bits 0..3, clock select bit 4, match enable bit 5.
   typedef struct packed {
      logic [1:0] rsvd;
      logic       match_service_enable;
      logic       watchdog_clock_select;
      logic       lock_reload;
      logic       lock_timer;
      logic       lock_prescaler;
      logic       lock_config;
   } timer_watchdog_config_t;

   localparam timer_watchdog_config_t CONFIG_RST = '0;

endpackage

`default_nettype wire

// >>> bench/tick_timer_watchdog_chk.sv
// Concurrent checks on the tick timer and watchdog ports.
// Assumes it is bound into the unit and sees only that unit's ports.
`default_nettype none

module tick_timer_watchdog_chk
   import tick_wdog_pkg::*;
#(
   parameter int SLOW_DIV = 2
) (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Freeze and events
   input wire logic        freeze,
   input wire logic        tick_irq,
   input wire logic        watchdog_error,
   input wire logic        watchdog_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // --------------------------------------------------------------------
   // Shadow state
   // --------------------------------------------------------------------
   logic match_r;
   logic lockc_r;
   logic lockt_r;
   logic inte_r;

   // Shadow of the match enable and interrupt enable; locks keep it honest.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         {match_r, lockc_r, lockt_r, inte_r} <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == OFS_CONFIG && !lockc_r) begin
            match_r <= reg_wdata[5];
            lockc_r <= reg_wdata[0];
            lockt_r <= lockt_r | reg_wdata[2];
         end
         if (reg_wr && reg_addr == OFS_CSR && !lockt_r) begin
            inte_r <= reg_wdata[CSR_INTE];
         end
      end
   end

   // Decoded requests seen on the register port.
   wire logic rd_wo   = reg_rd && (reg_addr == OFS_RELOAD || reg_addr == OFS_SERVICE);
   wire logic wr_rel  = reg_wr && reg_addr == OFS_RELOAD;
   wire logic bad_svc = reg_wr && reg_addr == OFS_SERVICE && match_r
                        && reg_wdata[7:0] != SERVICE_MATCH;

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_wo_read_zero: assert property (rd_wo |=> reg_rdata == 16'h0000)
      else $error("write-only register returned data");
   a_error_stays: assert property (watchdog_error |=> watchdog_error)
      else $error("watchdog error dropped");
   a_active_stays: assert property (watchdog_active |=> watchdog_active)
      else $error("watchdog went idle");
   a_active_cause: assert property ($rose(watchdog_active) |-> $past(wr_rel) || $past(wr_rel, 2))
      else $error("watchdog started without a reload count write");
   a_irq_single: assert property (tick_irq |=> !tick_irq [*2])
      else $error("tick interrupt longer than one cycle");
   a_irq_enabled: assert property (tick_irq |-> inte_r || $past(inte_r))
      else $error("tick interrupt while disabled");
   a_bad_service: assert property (bad_svc |-> ##[1:3] watchdog_error)
      else $error("bad service byte gave no error");

   // Main scenarios reached.
   c_irq: cover property (tick_irq);
   c_error: cover property ($rose(watchdog_error));
   c_active: cover property ($rose(watchdog_active));
endmodule

bind tick_timer_watchdog tick_timer_watchdog_chk #(.SLOW_DIV(SLOW_DIV)) chk_u (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freeze(freeze),
   .tick_irq(tick_irq), .watchdog_error(watchdog_error), .watchdog_active(watchdog_active));

`default_nettype wire

// >>> bench/tick_timer_watchdog_test.sv
// Self-checking bench for the tick timer and watchdog unit.
// Assumes a shortened slow clock divider so that every count stays brief.
`default_nettype none

module tick_timer_watchdog_test;
   timeunit 1ns;
   timeprecision 100ps;
   import tick_wdog_pkg::*;
   localparam int DIV = 2;

   logic        ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, freeze = 0, rd_seen = 0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, pre;
   logic        tick_irq, watchdog_error, watchdog_active;
   logic [15:0] exp_q[$];
   int          errors = 0, compares = 0, seed = 53173, n;

   always #12.5 ref_clk = ~ref_clk;

   tick_timer_watchdog #(.SLOW_DIV(DIV)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freeze(freeze),
      .tick_irq(tick_irq), .watchdog_error(watchdog_error), .watchdog_active(watchdog_active));

   // --------------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // The expected answer is noted before the strobe goes out.
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      exp_q.push_back(exp);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic do_reset;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
   endtask

   // Counts edges up to and including the next tick pulse, or gives up at lim.
   task automatic wait_irq(output int k, input int lim);
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (tick_irq !== 1'b1 && k < lim);
   endtask

   // Read answers stand only in the cycle after the strobe, so look there.
   always @(posedge ref_clk) begin
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end

   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial begin
      cyc(2);
      rst_n <= 1'b1;
      rd(OFS_PRESET, PRESET_RST);
      rd(OFS_CSR, 16'h0000);
      rd(OFS_RELOAD, 16'h0000);
      rd(4'hf, 16'h0000);
      check(16'(watchdog_active), 16'h0000);
      wr(OFS_CSR, 16'h0002);
      rd(OFS_CSR, 16'h0000);
      // Every divider code with a random preset; second interval is clean.
      for (int code = 0; code < 6; code++) begin
         pre = 16'(2 + {$random(seed)} % 3);
         wr(OFS_PRESCALER, 16'(code));
         wr(OFS_PRESET, pre);
         wr(OFS_CSR, 16'h0005);
         wait_irq(n, 2000);
         wait_irq(n, 2000);
         check(16'(n), 16'((pre + 1) * DIV * (1 << code)));
         rd(OFS_CSR, 16'h0006);
         rd(OFS_CSR, 16'h0004);
      end
      wr(OFS_CSR, 16'h0000);
      wait_irq(n, 600);
      check(16'(n), 16'd600);
      wr(OFS_PRESCALER, 16'h0000);
      wr(OFS_PRESET, 16'h0002);
      freeze <= 1'b1;
      wr(OFS_CSR, 16'h0015);
      wait_irq(n, 100);
      check(16'(n), 16'd100);
      freeze <= 1'b0;
      wait_irq(n, 100);
      check(16'(n < 100), 16'h0001);
      // Watchdog kept alive by count rewrites, then left to expire.
      do_reset();
      wr(OFS_PRESCALER, 16'h0001);
      cyc(40);
      check(16'(watchdog_active), 16'h0000);
      wr(OFS_RELOAD, 16'h0008);
      cyc(2);
      check(16'(watchdog_active), 16'h0001);
      rd(OFS_CSR, 16'h0008);
      wr(OFS_CONFIG, 16'h0010);
      cyc(8);
      rd(OFS_CSR, 16'h0000);
      repeat (5) begin
         cyc(20);
         wr(OFS_RELOAD, 16'h0008);
      end
      cyc(20);
      check(16'(watchdog_error), 16'h0000);
      cyc(24);
      check(16'(watchdog_error), 16'h0001);
      // Match servicing: ignored when off, keeps alive when on, double is an error.
      do_reset();
      wr(OFS_PRESCALER, 16'h0003);
      wr(OFS_CONFIG, 16'h0010);
      wr(OFS_RELOAD, 16'h0008);
      wr(OFS_SERVICE, 16'h0011);
      cyc(2);
      check(16'(watchdog_error), 16'h0000);
      wr(OFS_CONFIG, 16'h0030);
      repeat (5) begin
         cyc(80);
         wr(OFS_SERVICE, 16'h005c);
      end
      check(16'(watchdog_error), 16'h0000);
      repeat (3) wr(OFS_SERVICE, 16'h005c);
      cyc(3);
      check(16'(watchdog_error), 16'h0001);
      do_reset();
      wr(OFS_CONFIG, 16'h0030);
      wr(OFS_SERVICE, 16'({$random(seed)} % 8'h5c));
      cyc(3);
      check(16'(watchdog_error), 16'h0001);
      // A lock bit sticks and hides its register.
      wr(OFS_CONFIG, 16'h0002);
      wr(OFS_PRESCALER, 16'h0003);
      wr(OFS_CONFIG, 16'h0000);
      rd(OFS_CONFIG, 16'h0002);
      rd(OFS_PRESCALER, 16'h0000);
      cyc(4);
      results();
   end

   // Guards against a hang: the whole run needs well under this span.
   initial begin
      cyc(60000);
      errors++;
      results();
   end
endmodule

`default_nettype wire
